//--- core/nvm_ctrl_pkg.sv
package nvm_ctrl_pkg;

  // ==========================================================
  // Bus map
  localparam int unsigned ADDR_WIDTH = 17;
  localparam int unsigned ARRAY_WIDTH = 15;
  localparam int unsigned ARRAY_SELECT_BIT = 16;
  localparam logic [15:0] CONTROL_OFFSET = 16'h0000;
  localparam logic [15:0] BLOCK_PROTECT_OFFSET = 16'h0004;
  localparam logic [15:0] STATUS_OFFSET = 16'h0008;

  // ==========================================================
  // Control register fields
  localparam int unsigned PROGRAM_BIT = 0;
  localparam int unsigned ERASE_BIT = 1;
  localparam int unsigned MASS_BIT = 2;
  localparam int unsigned HV_BIT = 3;
  localparam logic [7:0] BLOCK_PROTECT_RESET = 8'hff;

  // ==========================================================
  // Status register fields
  localparam int unsigned STAT_READABLE_BIT = 0;
  localparam int unsigned STAT_ARMED_BIT = 1;
  localparam int unsigned STAT_ROW_ERROR_BIT = 2;
  localparam int unsigned STAT_RECOVERY_BIT = 3;

  // ==========================================================
  // Array geometry
  localparam int unsigned ROW_SHIFT = 6;
  localparam int unsigned PAGE_SHIFT = 7;

  // ==========================================================
  // Timing
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned RECOVERY_TIME_NS = 1000;
  localparam int unsigned RECOVERY_CYCLES = (RECOVERY_TIME_NS * CLOCK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    seq_idle,
    seq_selected,
    seq_protect_read,
    seq_armed,
    seq_high_voltage,
    seq_recovery
  } seq_state_type;

endpackage

//--- core/hold_timer.sv
`timescale 1ns/1ps
`default_nettype none

module hold_timer #(
  parameter int unsigned COUNT = 200
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  output logic busy
);

  localparam int unsigned WIDTH = $clog2(COUNT + 1);
  localparam logic [WIDTH-1:0] LOAD = WIDTH'(COUNT);
  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (start) begin
      count_next = LOAD;
    end else if (count_reg != '0) begin
      count_next = count_reg - ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy = (count_reg != '0);

endmodule

`default_nettype wire

//--- core/flash_program_erase_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - high voltage only after armed sequence
// - high voltage bit drives pump and array
// - mass bit picks whole array or page
// - program and erase never both set
// - program select latches array writes made under high voltage
// - array readable after recovery time
// - array contents hidden from bus reads
module flash_program_erase_ctrl
  import nvm_ctrl_pkg::*;
#(
  parameter int unsigned RECOVERY_COUNT = nvm_ctrl_pkg::RECOVERY_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [nvm_ctrl_pkg::ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic charge_pump_on,
  output logic array_high_voltage,
  output logic program_config,
  output logic erase_enable,
  output logic mass_erase,
  output logic [nvm_ctrl_pkg::ARRAY_WIDTH-1:0] target_addr,
  output logic latch_strobe,
  output logic [nvm_ctrl_pkg::ARRAY_WIDTH-1:0] latch_addr,
  output logic [7:0] latch_data,
  output logic array_readable
);
  import nvm_ctrl_pkg::*;

  // ==========================================================
  // State
  seq_state_type state_reg, state_next;
  logic program_reg, program_next;
  logic erase_reg, erase_next;
  logic mass_reg, mass_next;
  logic hv_reg, hv_next;
  logic row_error_reg, row_error_next;
  logic [7:0] protect_reg, protect_next;
  logic [ARRAY_WIDTH-1:0] target_reg, target_next;
  logic [ARRAY_WIDTH-1:0] latch_addr_reg, latch_addr_next;
  logic [7:0] latch_data_reg, latch_data_next;
  logic latch_strobe_reg, latch_strobe_next;
  logic erase_enable_reg, erase_enable_next;
  logic readable_reg, readable_next;
  logic waitrequest_reg, waitrequest_next;
  logic [31:0] readdata_reg, readdata_next;

  logic ack;
  logic in_array;
  logic [15:0] reg_offset;
  logic [ARRAY_WIDTH-1:0] array_offset;
  logic [7:0] wbyte;
  logic recovery_start;
  logic recovery_busy;
  logic [7:0] control_view;
  logic [7:0] status_view;

  assign in_array = address[ARRAY_SELECT_BIT];
  assign reg_offset = address[15:0];
  assign array_offset = address[ARRAY_WIDTH-1:0];
  assign wbyte = writedata[7:0];
  // Answer comes one cycle after the request is seen; effects land on the acknowledging edge
  assign ack = (read || write) && !waitrequest_reg;

  always_comb begin
    control_view = 8'h00;
    control_view[PROGRAM_BIT] = program_reg;
    control_view[ERASE_BIT] = erase_reg;
    control_view[MASS_BIT] = mass_reg;
    control_view[HV_BIT] = hv_reg;
    status_view = 8'h00;
    status_view[STAT_READABLE_BIT] = readable_reg;
    status_view[STAT_ARMED_BIT] = (state_reg == seq_armed);
    status_view[STAT_ROW_ERROR_BIT] = row_error_reg;
    status_view[STAT_RECOVERY_BIT] = (state_reg == seq_recovery);
  end

  // ==========================================================
  // Sequencer and register file
  always_comb begin
    state_next = state_reg;
    program_next = program_reg;
    erase_next = erase_reg;
    mass_next = mass_reg;
    hv_next = hv_reg;
    row_error_next = row_error_reg;
    protect_next = protect_reg;
    target_next = target_reg;
    latch_addr_next = latch_addr_reg;
    latch_data_next = latch_data_reg;
    latch_strobe_next = 1'b0;
    readdata_next = readdata_reg;
    waitrequest_next = 1'b1;
    recovery_start = 1'b0;

    if ((read || write) && waitrequest_reg) begin
      waitrequest_next = 1'b0;
      readdata_next = 32'h0000_0000;
      if (read && !in_array) begin
        case (reg_offset)
          CONTROL_OFFSET: readdata_next = {24'h00_0000, control_view};
          BLOCK_PROTECT_OFFSET: readdata_next = {24'h00_0000, protect_reg};
          STATUS_OFFSET: readdata_next = {24'h00_0000, status_view};
          default: readdata_next = 32'h0000_0000;
        endcase
      end
      // Array reads through this port always return zero so contents stay hidden
    end

    if (ack && write && !in_array && reg_offset == CONTROL_OFFSET) begin
      mass_next = wbyte[MASS_BIT];
      // A write asking for both selects leaves both unchanged
      if (!(wbyte[PROGRAM_BIT] && wbyte[ERASE_BIT])) begin
        program_next = wbyte[PROGRAM_BIT];
        erase_next = wbyte[ERASE_BIT];
      end
      if (wbyte[HV_BIT] && !hv_reg) begin
        // Arming keeps the selection that ran the steps; a select change in the same write restarts instead
        if (state_reg == seq_armed && program_next == program_reg && erase_next == erase_reg) begin
          hv_next = 1'b1;
          state_next = seq_high_voltage;
        end
      end else if (!wbyte[HV_BIT] && hv_reg) begin
        hv_next = 1'b0;
        recovery_start = 1'b1;
        state_next = seq_recovery;
      end
      if (!hv_reg && state_reg != seq_recovery) begin
        if (program_next != program_reg || erase_next != erase_reg) begin
          // Changing the selection restarts the step sequence
          state_next = (program_next || erase_next) ? seq_selected : seq_idle;
          row_error_next = 1'b0;
        end else if (!program_next && !erase_next) begin
          state_next = seq_idle;
        end
      end
    end

    if (ack && write && !in_array && reg_offset == BLOCK_PROTECT_OFFSET) begin
      protect_next = wbyte;
    end

    if (ack && read && !in_array && reg_offset == BLOCK_PROTECT_OFFSET && state_reg == seq_selected) begin
      state_next = seq_protect_read;
    end

    if (ack && write && in_array) begin
      if (state_reg == seq_protect_read) begin
        target_next = array_offset;
        state_next = seq_armed;
      end else if (state_reg == seq_high_voltage && program_reg) begin
        latch_strobe_next = 1'b1;
        latch_addr_next = array_offset;
        latch_data_next = wbyte;
        if (array_offset[ARRAY_WIDTH-1:ROW_SHIFT] != target_reg[ARRAY_WIDTH-1:ROW_SHIFT]) begin
          row_error_next = 1'b1;
        end
      end
    end

    if (state_reg == seq_recovery && !recovery_busy && !recovery_start) begin
      state_next = (program_next || erase_next) ? seq_selected : seq_idle;
    end

    erase_enable_next = hv_next && erase_next;
    readable_next = (state_next != seq_high_voltage) && (state_next != seq_recovery);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= seq_idle;
      program_reg <= 1'b0;
      erase_reg <= 1'b0;
      mass_reg <= 1'b0;
      hv_reg <= 1'b0;
      row_error_reg <= 1'b0;
      protect_reg <= BLOCK_PROTECT_RESET;
      target_reg <= '0;
      latch_addr_reg <= '0;
      latch_data_reg <= 8'h00;
      latch_strobe_reg <= 1'b0;
      erase_enable_reg <= 1'b0;
      readable_reg <= 1'b1;
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      program_reg <= program_next;
      erase_reg <= erase_next;
      mass_reg <= mass_next;
      hv_reg <= hv_next;
      row_error_reg <= row_error_next;
      protect_reg <= protect_next;
      target_reg <= target_next;
      latch_addr_reg <= latch_addr_next;
      latch_data_reg <= latch_data_next;
      latch_strobe_reg <= latch_strobe_next;
      erase_enable_reg <= erase_enable_next;
      readable_reg <= readable_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  // ==========================================================
  // Read recovery after high voltage drops
  hold_timer #(
    .COUNT(RECOVERY_COUNT)
  ) recovery_timer (
    .clock(clock),
    .rst(rst),
    .start(recovery_start),
    .busy(recovery_busy)
  );

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign charge_pump_on = hv_reg;
  assign array_high_voltage = hv_reg;
  assign program_config = program_reg;
  assign erase_enable = erase_enable_reg;
  assign mass_erase = mass_reg;
  assign target_addr = target_reg;
  assign latch_strobe = latch_strobe_reg;
  assign latch_addr = latch_addr_reg;
  assign latch_data = latch_data_reg;
  assign array_readable = readable_reg;

  // ==========================================================
  // Checks
  property p_hv_only_when_armed;
    @(posedge clock) disable iff (rst)
      $rose(hv_reg) |-> $past(state_reg) == seq_armed && $stable(program_reg) && $stable(erase_reg) &&
        (program_reg || erase_reg);
  endproperty
  a_hv_only_when_armed: assert property (p_hv_only_when_armed) else $error("high voltage set out of sequence");

  property p_pump_tracks_hv;
    @(posedge clock) disable iff (rst)
      $rose(hv_reg) |-> charge_pump_on && array_high_voltage && !array_readable;
  endproperty
  a_pump_tracks_hv: assert property (p_pump_tracks_hv) else $error("pump or array voltage wrong");

  property p_mass_scope;
    @(posedge clock) disable iff (rst)
      $rose(erase_enable) |-> erase_reg && hv_reg && mass_erase == $past(writedata[MASS_BIT]);
  endproperty
  a_mass_scope: assert property (p_mass_scope) else $error("erase scope mismatch");

  property p_interlock;
    @(posedge clock) disable iff (rst)
      !(program_reg && erase_reg);
  endproperty
  a_interlock: assert property (p_interlock) else $error("program and erase both set");

  property p_latch_needs_program;
    @(posedge clock) disable iff (rst)
      latch_strobe |-> program_config && $past(state_reg) == seq_high_voltage;
  endproperty
  a_latch_needs_program: assert property (p_latch_needs_program) else $error("latch outside program");

  property p_recovery_hold;
    @(posedge clock) disable iff (rst)
      $fell(hv_reg) |-> !array_readable [*8];
  endproperty
  a_recovery_hold: assert property (p_recovery_hold) else $error("array readable too early");

  property p_array_read_hidden;
    @(posedge clock) disable iff (rst)
      read && in_array && !waitrequest |-> readdata == 32'h0000_0000;
  endproperty
  a_array_read_hidden: assert property (p_array_read_hidden) else $error("array data exposed");

  property p_hv_write_latches;
    @(posedge clock) disable iff (rst)
      ack && write && in_array && hv_reg && program_reg |=> latch_strobe && latch_data == $past(writedata[7:0]);
  endproperty
  a_hv_write_latches: assert property (p_hv_write_latches) else $error("program write not latched");

  c_program_hv: cover property (@(posedge clock) disable iff (rst) latch_strobe);
  c_erase_hv: cover property (@(posedge clock) disable iff (rst) erase_enable && !mass_erase);
  c_recovered: cover property (@(posedge clock) disable iff (rst) $rose(array_readable));

endmodule

`default_nettype wire

//--- sim/flash_program_erase_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_ctrl_test;
  import nvm_ctrl_pkg::*;
  // Short recovery keeps the run brief; expectations derive from it
  localparam int unsigned RC = 10;
  // Minimum software waits at 200 MHz: setup 10 us, program setup 5 us, byte 30 us, hold 5 us
  localparam int unsigned NVS = 2000;
  localparam int unsigned PGS = 1000;
  localparam int unsigned PROG = 6000;
  localparam int unsigned NVH = 1000;
  localparam logic RD = 1'b0;
  localparam logic WR = 1'b1;
  localparam logic [16:0] CTRL = {1'b0, CONTROL_OFFSET};
  localparam logic [16:0] BP = {1'b0, BLOCK_PROTECT_OFFSET};
  localparam logic [16:0] STAT = {1'b0, STATUS_OFFSET};
  localparam logic [16:0] ARR = 17'h10000;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [16:0] address = 17'h00000;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest, charge_pump_on, array_high_voltage, program_config, erase_enable, mass_erase;
  logic latch_strobe, array_readable;
  logic [14:0] target_addr, latch_addr;
  logic [7:0] latch_data;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int st = 0, m_sel = 0, m_hv = 0, m_mass = 0, m_row_err = 0, m_target = 0, m_bp = 255;
  int lq[$];
  int base, off, i;

  flash_program_erase_ctrl #(.RECOVERY_COUNT(RC)) i_flash_program_erase_ctrl (.clock(clock), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .charge_pump_on(charge_pump_on), .array_high_voltage(array_high_voltage),
    .program_config(program_config), .erase_enable(erase_enable), .mass_erase(mass_erase),
    .target_addr(target_addr), .latch_strobe(latch_strobe), .latch_addr(latch_addr),
    .latch_data(latch_data), .array_readable(array_readable));

  always #2.5 clock = ~clock;

  // ==========================================================
  // Reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    // The byte and setup waits dominate, about 32000 cycles in all
    if (cycles == 45000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // Behavioural model of the select, arm and latch sequence
  function automatic logic [31:0] exp_read(input logic [16:0] a);
    if (a[16]) return 32'h00000000;
    case (a[15:0])
      CONTROL_OFFSET: return 32'(m_hv * 8 + m_mass * 4 + m_sel);
      BLOCK_PROTECT_OFFSET: return 32'(m_bp);
      STATUS_OFFSET: return 32'((m_hv == 0) + 2 * (st == 3) + 4 * m_row_err);
      default: return 32'h00000000;
    endcase
  endfunction

  task automatic model(input logic w, input logic [16:0] a, input logic [7:0] d);
    int sel;
    if (a[16]) begin
      if (w && st == 2) begin
        st = 3;
        m_target = a[14:0];
      end else if (w && st == 4 && m_sel == 1) begin
        // A stray row still latches but flags the row error
        if (a[14:6] != m_target[14:6]) m_row_err = 1;
        lq.push_back({a[14:0], d});
      end
    end else if (!w && a[15:0] == BLOCK_PROTECT_OFFSET && st == 1) st = 2;
    else if (w && a[15:0] == BLOCK_PROTECT_OFFSET) m_bp = d;
    else if (w && a[15:0] == CONTROL_OFFSET) begin
      // A write asking for both selects leaves the old selection alone
      sel = (d[1:0] == 2'h3) ? m_sel : d[1:0];
      if (sel != m_sel && st != 4) m_row_err = 0;
      if (st == 4) begin
        if (!d[3]) st = (sel != 0) ? 1 : 0;
      end else if (sel != m_sel) st = (sel != 0) ? 1 : 0;
      else if (d[3] && st == 3) st = 4;
      m_sel = sel;
      m_mass = d[2];
      m_hv = (st == 4);
    end
  endtask

  // ==========================================================
  // Avalon access, then model update and output comparison
  task automatic acc(input logic w, input logic [16:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic [31:0] e;
    int n;
    e = exp_read(a);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {24'($urandom()), d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    check(32'(n < 50), 32'h00000001, "answer");
    if (!w) check(rd, e, "read data");
    model(w, a, d);
    @(posedge clock);
    check(32'({charge_pump_on, array_high_voltage, program_config, erase_enable, mass_erase}),
      32'({m_hv[0], m_hv[0], m_sel[0], m_hv[0] & m_sel[1], m_mass[0]}), "controls");
  endtask

  task automatic recovery();
    int n;
    n = 0;
    while (array_readable !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    check(32'(n >= RC - 2 && n <= RC + 4), 32'h00000001, "recovery time");
  endtask

  // Latched program bytes must come out in write order
  always @(posedge clock) begin
    if (latch_strobe === 1'b1) begin
      if (lq.size() == 0) check(32'h00000001, 32'h00000000, "stray latch");
      else check(32'({latch_addr, latch_data}), 32'(lq.pop_front()), "latch");
    end
  end

  // ==========================================================
  // Scenarios
  // Steps run in order except in the refused arm test, with unrelated register accesses between them
  // No code runs from the array and no interrupt is ever raised here
  initial begin
    void'($urandom(46964));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    acc(RD, CTRL, 8'h00);
    acc(RD, BP, 8'h00);
    acc(RD, STAT, 8'h00);
    acc(RD, 17'h0000c, 8'h00);
    acc(RD, ARR | 17'($urandom_range(32767, 0)), 8'h00);
    check(32'(array_readable), 32'h00000001, "readable at reset");
    $display("reset test done");
    for (i = 1; i < 3; i++) begin
      acc(WR, CTRL, 8'(i));
      acc(WR, CTRL, 8'h03);
      acc(RD, CTRL, 8'h00);
    end
    acc(WR, CTRL, 8'h00);
    $display("interlock test done");
    acc(WR, CTRL, 8'h08);
    acc(WR, CTRL, 8'h01);
    acc(WR, ARR, 8'h00);
    acc(WR, CTRL, 8'h09);
    acc(RD, BP, 8'h00);
    acc(WR, CTRL, 8'h09);
    acc(RD, CTRL, 8'h00);
    acc(WR, CTRL, 8'h00);
    $display("refused arm test done");
    for (i = 0; i < 2; i++) begin
      off = $urandom_range(32767, 0);
      acc(WR, CTRL, 8'(2 + 4 * i));
      acc(RD, BP, 8'h00);
      acc(WR, ARR | 17'(off), 8'($urandom()));
      check(32'(target_addr), 32'(m_target), "target");
      acc(RD, STAT, 8'h00);
      repeat (NVS) @(posedge clock);
      acc(WR, CTRL, 8'(10 + 4 * i));
      check(32'(array_readable), 32'h00000000, "readable under high voltage");
      acc(WR, CTRL, 8'(2 + 4 * i));
      recovery();
      acc(WR, CTRL, 8'h00);
    end
    $display("erase test done");
    base = $urandom_range(32767, 0) & 32'h00007fc0;
    // The row lies in the array just mass erased, and each offset is written once
    acc(WR, CTRL, 8'h01);
    acc(RD, BP, 8'h00);
    acc(WR, ARR | 17'(base + $urandom_range(63, 0)), 8'h00);
    repeat (NVS) @(posedge clock);
    acc(WR, CTRL, 8'h09);
    repeat (PGS) @(posedge clock);
    off = $urandom_range(15, 0);
    for (i = 0; i < 4; i++) begin
      acc(WR, ARR | 17'(base + 16 * i + off), 8'($urandom()));
      // Minimum byte time only, so per-byte and cumulative voltage times stay short
      repeat (PROG) @(posedge clock);
    end
    acc(RD, ARR | 17'(base), 8'h00);
    acc(WR, ARR | 17'(base ^ 32'h00000040), 8'h55);
    acc(RD, STAT, 8'h00);
    acc(WR, CTRL, 8'h08);
    repeat (NVH) @(posedge clock);
    acc(WR, CTRL, 8'h00);
    recovery();
    check(32'(lq.size()), 32'h00000000, "latched count");
    $display("program test done");
    acc(WR, BP, 8'h3c);
    acc(RD, BP, 8'h00);
    $display("protect register test done");
    give_verdict();
  end
endmodule

`default_nettype wire
